// ===== verilog/bgdc_top.sv
// Behaviour
// - Non-negative test rate always reads sufficient
// - Negative rate: can charge cover ten seconds
// - New rate refreshes flag promptly
// - Flag refreshed from stored rate every second
// - Temperature word in tenth kelvin
// - Voltage word in millivolts, unsigned
// - Current word signed milliamps
// - Average current via single-pole filter
// - Full reset loads margin with 100
// - Clean learning cycle sets margin 2
// - Limited learning sets 8 unless lower
// - Four cycle steps without learning add one
// - Voltage correction sets margin 25
// - Margin word stays within 2 to 100
// - Relative charge percent of learned size
// - Absolute charge percent of nominal size
// - Charge left word in chosen units
// - Learned size word in chosen units
// - Each value answered as one word
// - Stored test rate signed, zero after reset
// - Unit select chooses current or power units
module bgdc_top
  import bgdc_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYCLES_DFLT
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        rd_req,
  input  wire logic [7:0]  rd_cmd,
  output logic             rd_valid,
  output logic             rd_error,
  output logic      [15:0] rd_word,
  input  wire logic        rate_wr,
  input  wire logic [15:0] host_test_rate,
  input  wire logic        cap_mode,
  input  wire logic        meas_stb,
  input  wire logic [15:0] meas_temp,
  input  wire logic [15:0] meas_volt,
  input  wire logic [15:0] meas_flow,
  input  wire logic [15:0] left_mah,
  input  wire logic [15:0] left_cwh,
  input  wire logic [15:0] learned_mah,
  input  wire logic [15:0] learned_cwh,
  input  wire logic [15:0] nominal_mah,
  input  wire logic [15:0] nominal_cwh,
  input  wire logic        learn_done,
  input  wire logic        learn_limited,
  input  wire logic        cycle_tally_inc,
  input  wire logic        vcorr_stb,
  output logic             rate_sufficiency_flag,
  output logic      [6:0]  charge_error_margin
);

  typedef struct packed {
    bgdc_rd_t            rd_state;
    logic                rd_error;
    logic [15:0]         rd_word;
    logic [15:0]         rate;
    logic                ok_flag;
    logic [TICK_W-1:0]   tick_cnt;
    logic [6:0]          margin;
    logic [1:0]          cyc_cnt;
    logic [15:0]         temp;
    logic [15:0]         volt;
    logic [15:0]         flow;
    logic [6:0]          rel_pct;
    logic [15:0]         abs_pct;
    logic [15:0]         left;
    logic [15:0]         full;
  } bgdc_state_t;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(REFRESH_CYCLES - 1);

  localparam bgdc_state_t ST_RESET = '{
    rd_state: RD_IDLE,
    rd_error: 1'b0,
    rd_word:  WORD_RESET,
    rate:     RATE_RESET,
    ok_flag:  OK_RESET,
    tick_cnt: '0,
    margin:   MARGIN_RESET,
    cyc_cnt:  2'h0,
    temp:     WORD_RESET,
    volt:     WORD_RESET,
    flow:     WORD_RESET,
    rel_pct:  7'h00,
    abs_pct:  WORD_RESET,
    left:     WORD_RESET,
    full:     WORD_RESET
  };

  logic              rst_meta_n;
  logic              rst_n;
  bgdc_state_t       st_reg;
  bgdc_state_t       st_next;
  logic [15:0]       avg_flow;
  logic [15:0]       left_sel;
  logic [15:0]       full_sel;
  logic [15:0]       nominal_sel;
  logic [16:0]       disch_mag;
  logic              tick;
  logic              cyc_step;
  logic [15:0]       rel_raw;
  logic [15:0]       sel_word;
  logic              sel_known;

  // Sufficiency: charge left scaled to the hold time against extra plus present drain
  function automatic logic ok_of(input logic [15:0] rate,
                                 input logic [15:0] left,
                                 input logic [16:0] disch);
    logic [16:0] mag;
    logic [17:0] need;
    logic [24:0] have;
    // Magnitude in 17 bits so that -32768 still fits without a carry
    mag  = 17'h00000 - {rate[15], rate};
    need = {1'b0, mag} + {1'b0, disch};
    have = left * OK_SCALE;
    if (!rate[15]) begin
      return 1'b1;
    end
    return have >= {7'h00, need};
  endfunction : ok_of

  // Whole percent of num over den, saturated; zero when den is zero
  function automatic logic [15:0] pct_of(input logic [15:0] num,
                                         input logic [15:0] den);
    logic [22:0] scaled;
    logic [23:0] q;
    scaled = num * PCT_SCALE;
    q      = 24'h000000;
    if (den != 16'h0000) begin
      q = {1'b0, scaled} / {8'h00, den};
    end
    return (q[23:16] != 8'h00) ? 16'hffff : q[15:0];
  endfunction : pct_of

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Average of the current samples
  bgdc_iir u_iir (
    .clk        (ref_clk),
    .rst_n      (rst_n),
    .sample_stb (meas_stb),
    .sample     (meas_flow),
    .avg        (avg_flow)
  );

  // Unit select picks the capacity set; power mode has no drain term
  assign left_sel    = cap_mode ? left_cwh : left_mah;
  assign full_sel    = cap_mode ? learned_cwh : learned_mah;
  assign nominal_sel = cap_mode ? nominal_cwh : nominal_mah;
  assign disch_mag   = (!cap_mode && avg_flow[15]) ?
                       (17'h00000 - {avg_flow[15], avg_flow}) : 17'h00000;
  assign rel_raw     = pct_of(left_sel, full_sel);
  assign tick        = st_reg.tick_cnt == TICK_LAST;
  assign cyc_step    = !learn_done && cycle_tally_inc && (st_reg.cyc_cnt == CYC_LAST);

  // Word selection for the command code
  always_comb begin
    sel_word  = WORD_RESET;
    sel_known = 1'b1;
    case (rd_cmd)
      CMD_RATE_OK:  sel_word = {15'h0000, st_reg.ok_flag};
      CMD_TEMP:     sel_word = st_reg.temp;
      CMD_VOLT:     sel_word = st_reg.volt;
      CMD_FLOW:     sel_word = st_reg.flow;
      CMD_AVG_FLOW: sel_word = avg_flow;
      CMD_MARGIN:   sel_word = {9'h000, st_reg.margin};
      CMD_REL_PCT:  sel_word = {9'h000, st_reg.rel_pct};
      CMD_ABS_PCT:  sel_word = st_reg.abs_pct;
      CMD_LEFT:     sel_word = st_reg.left;
      CMD_FULL:     sel_word = st_reg.full;
      default:      sel_known = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;

    // Refresh timer free-runs; a host write does not restart it
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + TICK_W'(1);

    // Host write stores the rate and recomputes on the spot
    if (rate_wr) begin
      st_next.rate    = host_test_rate;
      st_next.ok_flag = ok_of(host_test_rate, left_sel, disch_mag);
    end else if (tick) begin
      st_next.ok_flag = ok_of(st_reg.rate, left_sel, disch_mag);
    end

    // Measurements taken on the sample strobe only
    if (meas_stb) begin
      st_next.temp = meas_temp;
      st_next.volt = meas_volt;
      st_next.flow = meas_flow;
    end

    // Capacity words follow the selected units every cycle
    st_next.left    = left_sel;
    st_next.full    = full_sel;
    st_next.abs_pct = pct_of(left_sel, nominal_sel);
    st_next.rel_pct = (rel_raw > {9'h000, PCT_MAX}) ? PCT_MAX : rel_raw[6:0];

    // Cycle steps since the last learning cycle
    if (learn_done) begin
      st_next.cyc_cnt = 2'h0;
    end else if (cycle_tally_inc) begin
      st_next.cyc_cnt = (st_reg.cyc_cnt == CYC_LAST) ? 2'h0 : st_reg.cyc_cnt + 2'h1;
    end

    // Margin: voltage correction outranks learning, learning outranks aging
    if (vcorr_stb) begin
      st_next.margin = MARGIN_VCORR;
    end else if (learn_done && !learn_limited) begin
      st_next.margin = MARGIN_LEARNED;
    end else if (learn_done) begin
      if (st_reg.margin >= MARGIN_LIMITED) begin
        st_next.margin = MARGIN_LIMITED;
      end
    end else if (cyc_step && (st_reg.margin < MARGIN_MAX)) begin
      st_next.margin = st_reg.margin + MARGIN_STEP;
    end

    // Read engine: every request answered next cycle, back to back allowed
    case (st_reg.rd_state)
      RD_IDLE, RD_ANSWER: begin
        if (rd_req) begin
          st_next.rd_state = RD_ANSWER;
          st_next.rd_word  = sel_word;
          st_next.rd_error = !sel_known;
        end else begin
          st_next.rd_state = RD_IDLE;
          st_next.rd_error = 1'b0;
        end
      end
      default: begin
        st_next.rd_state = RD_IDLE;
      end
    endcase
  end

  // Single state register; reset loads full margin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign rd_valid              = st_reg.rd_state == RD_ANSWER;
  assign rd_error              = st_reg.rd_error;
  assign rd_word               = st_reg.rd_word;
  assign rate_sufficiency_flag = st_reg.ok_flag;
  assign charge_error_margin   = st_reg.margin;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (!rst_n);

  sequence s_rd_take;
    rd_req && sel_known;
  endsequence

  sequence s_rd_give;
    rd_valid && !rd_error;
  endsequence

  sequence s_learn_clean;
    learn_done && !learn_limited && !vcorr_stb;
  endsequence

  a_ok_nonneg: assert property (rate_wr && !host_test_rate[15] |=> rate_sufficiency_flag)
    else $error("non-negative rate did not give sufficient flag");

  a_ok_recalc: assert property (rate_wr |=> rate_sufficiency_flag ==
                                ok_of($past(host_test_rate), $past(left_sel),
                                      $past(disch_mag)))
    else $error("flag not recomputed after rate write");

  a_ok_negative: assert property (rate_wr && host_test_rate[15] && left_sel == 16'h0000
                                  |=> !rate_sufficiency_flag)
    else $error("empty pack reported sufficient for discharge");

  a_ok_refresh: assert property (tick && !rate_wr |=> rate_sufficiency_flag ==
                                 ok_of($past(st_reg.rate), $past(left_sel),
                                       $past(disch_mag)))
    else $error("scheduled refresh did not recompute flag");

  a_tick_bound: assert property (st_reg.tick_cnt <= TICK_LAST)
    else $error("refresh timer beyond its period");

  a_margin_reset: assert property ($rose(rst_n) |-> charge_error_margin == MARGIN_RESET)
    else $error("margin not full after reset");

  a_margin_learn: assert property (s_learn_clean |=> charge_error_margin == MARGIN_LEARNED)
    else $error("clean learning cycle did not set margin");

  a_margin_limit: assert property (learn_done && learn_limited && !vcorr_stb
                                   |=> charge_error_margin ==
                                   (($past(charge_error_margin) < MARGIN_LIMITED) ?
                                    $past(charge_error_margin) : MARGIN_LIMITED))
    else $error("limited learning cycle margin wrong");

  a_margin_age: assert property (cyc_step && !vcorr_stb && charge_error_margin < MARGIN_MAX
                                 |=> charge_error_margin ==
                                 $past(charge_error_margin) + MARGIN_STEP)
    else $error("margin did not age after four cycle steps");

  a_margin_vcorr: assert property (vcorr_stb |=> charge_error_margin == MARGIN_VCORR)
    else $error("voltage correction did not set margin");

  a_margin_range: assert property (charge_error_margin >= MARGIN_MIN &&
                                   charge_error_margin <= MARGIN_MAX)
    else $error("margin out of range");

  a_rel_range: assert property (st_reg.rel_pct <= PCT_MAX)
    else $error("relative charge above full");

  a_units_left: assert property (##1 st_reg.left == $past(left_sel))
    else $error("charge left not in selected units");

  a_read_word: assert property (s_rd_take |=> s_rd_give and (rd_word == $past(sel_word)))
    else $error("read request not answered with its word");

  a_read_unmapped: assert property (rd_req && !sel_known |=> rd_valid && rd_error &&
                                    rd_word == WORD_RESET)
    else $error("unmapped code not flagged");

endmodule : bgdc_top

// ===== shared/bgdc_pkg.sv
package bgdc_pkg;

  // Command codes served as read-word answers
  localparam logic [7:0]  CMD_RATE_OK   = 8'h07;
  localparam logic [7:0]  CMD_TEMP      = 8'h08;
  localparam logic [7:0]  CMD_VOLT      = 8'h09;
  localparam logic [7:0]  CMD_FLOW      = 8'h0a;
  localparam logic [7:0]  CMD_AVG_FLOW  = 8'h0b;
  localparam logic [7:0]  CMD_MARGIN    = 8'h0c;
  localparam logic [7:0]  CMD_REL_PCT   = 8'h0d;
  localparam logic [7:0]  CMD_ABS_PCT   = 8'h0e;
  localparam logic [7:0]  CMD_LEFT      = 8'h0f;
  localparam logic [7:0]  CMD_FULL      = 8'h10;

  // Clock and timing
  localparam int          CLK_HZ              = 10_000_000;
  localparam int          REFRESH_TIME_MS     = 1000;
  localparam int          REFRESH_CYCLES_DFLT = REFRESH_TIME_MS * (CLK_HZ / 1000);
  localparam int          RECALC_TIME_MS      = 5;
  localparam int          RECALC_CYCLES_DFLT  = RECALC_TIME_MS * (CLK_HZ / 1000);
  localparam int          TICK_W              = 24;

  // Sufficiency test: charge in unit-hours against rate over the hold time
  localparam int          OK_HOLD_TIME_S      = 10;
  localparam int          SEC_PER_HOUR        = 3600;
  localparam logic [8:0]  OK_SCALE            = 9'(SEC_PER_HOUR / OK_HOLD_TIME_S);

  // Average filter, alpha in 16 fraction bits
  localparam int          IIR_TAU_MS          = 14500;
  localparam int          SAMPLE_PERIOD_MS    = 1000;
  localparam logic [16:0] IIR_ALPHA           = 17'((65536 * SAMPLE_PERIOD_MS) / IIR_TAU_MS);
  localparam int          IIR_FRAC            = 16;

  // Error margin values in whole percent
  localparam logic [6:0]  MARGIN_RESET        = 7'h64;
  localparam logic [6:0]  MARGIN_LEARNED      = 7'h02;
  localparam logic [6:0]  MARGIN_LIMITED      = 7'h08;
  localparam logic [6:0]  MARGIN_VCORR        = 7'h19;
  localparam logic [6:0]  MARGIN_MIN          = 7'h02;
  localparam logic [6:0]  MARGIN_MAX          = 7'h64;
  localparam logic [6:0]  MARGIN_STEP         = 7'h01;
  localparam logic [1:0]  CYC_LAST            = 2'h3;

  // Percent scale and reset values
  localparam logic [6:0]  PCT_SCALE           = 7'h64;
  localparam logic [6:0]  PCT_MAX             = 7'h64;
  localparam logic [15:0] RATE_RESET          = 16'h0000;
  localparam logic        OK_RESET            = 1'b1;
  localparam logic [15:0] WORD_RESET          = 16'h0000;

  // Read answer engine
  typedef enum logic [0:0] {
    RD_IDLE   = 1'b0,
    RD_ANSWER = 1'b1
  } bgdc_rd_t;

endpackage : bgdc_pkg

// ===== verilog/bgdc_iir.sv
module bgdc_iir
  import bgdc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sample_stb,
  input  wire logic [15:0] sample,
  output logic      [15:0] avg
);

  typedef struct packed {
    logic        seeded;
    logic [31:0] acc;
  } bgdc_iir_state_t;

  bgdc_iir_state_t        st_reg;
  bgdc_iir_state_t        st_next;
  logic signed     [32:0] diff;
  logic signed     [50:0] prod;

  // Single-pole step: acc += (x - acc) * alpha; first sample seeds it
  always_comb begin
    st_next = st_reg;
    diff    = $signed({sample[15], sample, 16'h0000}) - $signed({st_reg.acc[31], st_reg.acc});
    prod    = diff * $signed({1'b0, IIR_ALPHA});
    if (sample_stb) begin
      if (!st_reg.seeded) begin
        st_next.acc    = {sample, 16'h0000};
        st_next.seeded = 1'b1;
      end else begin
        st_next.acc = st_reg.acc + prod[IIR_FRAC +: 32];
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avg = st_reg.acc[31:16];

endmodule : bgdc_iir

// ===== dv/bgdc_host_model.sv
module bgdc_host_model
  import bgdc_pkg::*;
(
  input  wire logic        clk,
  output logic             rd_req,
  output logic      [7:0]  rd_cmd,
  input  wire logic        rd_valid,
  input  wire logic        rd_error,
  input  wire logic [15:0] rd_word,
  output logic             rate_wr,
  output logic      [15:0] host_test_rate
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    rd_req         = 1'b0;
    rd_cmd         = 8'h00;
    rate_wr        = 1'b0;
    host_test_rate = 16'h0000;
  end

  // One read-word: a one-cycle request, then a bounded wait for the answer
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] word,
                           output logic err);
    int n;
    n = 0;
    @(posedge clk);
    rd_req <= 1'b1;
    rd_cmd <= cmd;
    @(posedge clk);
    rd_req <= 1'b0;
    rd_cmd <= ~cmd;                         // Stale code is not left on the lines
    #1;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    word = (rd_valid === 1'b1) ? rd_word : 16'hdead;  // Missing answer never matches
    err  = (rd_valid === 1'b1) ? rd_error : 1'bx;
  endtask : read_word

  // Host writes a new signed test rate
  task automatic write_rate(input logic [15:0] rate);
    @(posedge clk);
    rate_wr        <= 1'b1;
    host_test_rate <= rate;
    @(posedge clk);
    rate_wr        <= 1'b0;
    host_test_rate <= ~rate;                // Value is gone once the write is taken
  endtask : write_rate
endmodule : bgdc_host_model

// ===== dv/testbench.sv
module testbench
  import bgdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int REFRESH = 20;
  logic ref_clk = 1'b0, resetn = 1'b0, rd_req, rd_valid, rd_error, rate_wr, cap_mode = 1'b0;
  logic meas_stb = 1'b0, learn_done = 1'b0, learn_limited = 1'b0;
  logic cycle_tally_inc = 1'b0, vcorr_stb = 1'b0, rate_sufficiency_flag, err;
  logic [7:0]  rd_cmd;
  logic [6:0]  charge_error_margin;
  logic [15:0] rd_word, host_test_rate, word;
  logic [15:0] meas_temp = 16'h0, meas_volt = 16'h0, meas_flow = 16'h0;
  logic [15:0] left_mah = 16'h0, left_cwh = 16'h0, learned_mah = 16'h0, learned_cwh = 16'h0;
  logic [15:0] nominal_mah = 16'h0, nominal_cwh = 16'h0;
  int mismatches = 0, tests_run = 0, cycles = 0;
  logic [1:0] ek [15] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h2, 2'h2,
                          2'h2, 2'h2, 2'h1, 2'h3};
  logic [6:0] em [15] = '{7'h64, 7'h64, 7'h64, 7'h64, 7'h02, 7'h02, 7'h02, 7'h02, 7'h02,
                          7'h02, 7'h02, 7'h02, 7'h03, 7'h03, 7'h19};

  always #50 ref_clk = ~ref_clk;

  bgdc_top #(.REFRESH_CYCLES(REFRESH)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .rd_req(rd_req), .rd_cmd(rd_cmd),
    .rd_valid(rd_valid), .rd_error(rd_error), .rd_word(rd_word), .rate_wr(rate_wr),
    .host_test_rate(host_test_rate), .cap_mode(cap_mode), .meas_stb(meas_stb),
    .meas_temp(meas_temp), .meas_volt(meas_volt), .meas_flow(meas_flow),
    .left_mah(left_mah), .left_cwh(left_cwh), .learned_mah(learned_mah),
    .learned_cwh(learned_cwh), .nominal_mah(nominal_mah), .nominal_cwh(nominal_cwh),
    .learn_done(learn_done), .learn_limited(learn_limited),
    .cycle_tally_inc(cycle_tally_inc), .vcorr_stb(vcorr_stb),
    .rate_sufficiency_flag(rate_sufficiency_flag), .charge_error_margin(charge_error_margin));

  bgdc_host_model i_host (
    .clk(ref_clk), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_valid(rd_valid),
    .rd_error(rd_error), .rd_word(rd_word), .rate_wr(rate_wr),
    .host_test_rate(host_test_rate));

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read one command and compare both word and error flag
  task automatic rdchk(input logic [7:0] cmd, input logic [15:0] exp, input logic experr);
    i_host.read_word(cmd, word, err);
    chk(word, exp);
    chk({15'h0, err}, {15'h0, experr});
  endtask : rdchk

  // Margin event: 0 clean learn, 1 limited learn, 2 cycle step, 3 voltage correction
  task automatic ev(input logic [1:0] k);
    @(posedge ref_clk);
    learn_done      <= (k < 2'h2);
    learn_limited   <= (k == 2'h1);
    cycle_tally_inc <= (k == 2'h2);
    vcorr_stb       <= (k == 2'h3);
    @(posedge ref_clk);
    {learn_done, learn_limited, cycle_tally_inc, vcorr_stb} <= 4'h0;
    #1;
  endtask : ev

  task automatic meas(input logic [15:0] t, input logic [15:0] v, input logic [15:0] f);
    @(posedge ref_clk);
    meas_stb  <= 1'b1;
    meas_temp <= t;
    meas_volt <= v;
    meas_flow <= f;
    @(posedge ref_clk);
    meas_stb  <= 1'b0;
    repeat (4) @(posedge ref_clk);           // Filter steps once, on the strobe only; these cycles are idle gap
  endtask : meas

  task automatic rate(input logic [15:0] r, input logic exp);
    i_host.write_rate(r);
    #1;
    chk({15'h0, rate_sufficiency_flag}, {15'h0, exp});
  endtask : rate

  // Hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    int n;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({9'h0, charge_error_margin}, 16'h0064);
    chk({15'h0, rate_sufficiency_flag}, 16'h0001);
    rdchk(CMD_MARGIN, 16'h0064, 1'b0);
    rdchk(CMD_RATE_OK, 16'h0001, 1'b0);
    // Empty pack cannot cover even the smallest extra discharge
    rate(16'hffff, 1'b0);
    // Unknown codes on both sides of the served range
    rdchk(8'h06, 16'h0000, 1'b1);
    rdchk(8'h11, 16'h0000, 1'b1);
    rdchk(8'hff, 16'h0000, 1'b1);
    // Measurements, voltage at its top boundary
    meas(16'h0bb8, 16'h4e20, 16'hfc18);
    rdchk(CMD_TEMP, 16'h0bb8, 1'b0);
    rdchk(CMD_VOLT, 16'h4e20, 1'b0);
    rdchk(CMD_FLOW, 16'hfc18, 1'b0);
    rdchk(CMD_AVG_FLOW, 16'hfc18, 1'b0);
    meas(16'h0000, 16'h0000, 16'h7fff);
    rdchk(CMD_FLOW, 16'h7fff, 1'b0);
    // One step from -1000 toward 32767 by alpha, fraction dropped
    i_host.read_word(CMD_AVG_FLOW, word, err);
    chk(word, 16'((33767 * int'(IIR_ALPHA) - 65_536_000) >>> IIR_FRAC));
    // Margin event table
    for (int i = 0; i < 15; i++) begin
      ev(ek[i]);
      chk({9'h0, charge_error_margin}, {9'h0, em[i]});
    end
    rdchk(CMD_MARGIN, 16'h0019, 1'b0);
    ev(2'h1);
    rdchk(CMD_MARGIN, 16'h0008, 1'b0);
    // Capacity words and percents in both unit sets
    @(posedge ref_clk);
    left_mah    <= 16'h01f4;
    learned_mah <= 16'h03e8;
    nominal_mah <= 16'h0190;
    left_cwh    <= 16'h000a;
    learned_cwh <= 16'h0028;
    nominal_cwh <= 16'h0005;
    rdchk(CMD_LEFT, 16'h01f4, 1'b0);
    rdchk(CMD_FULL, 16'h03e8, 1'b0);
    rdchk(CMD_REL_PCT, 16'h0032, 1'b0);
    rdchk(CMD_ABS_PCT, 16'h007d, 1'b0);
    @(posedge ref_clk);
    left_mah <= 16'h05dc;
    rdchk(CMD_REL_PCT, 16'h0064, 1'b0);
    rdchk(CMD_ABS_PCT, 16'h0177, 1'b0);
    @(posedge ref_clk);
    cap_mode <= 1'b1;
    rdchk(CMD_LEFT, 16'h000a, 1'b0);
    rdchk(CMD_FULL, 16'h0028, 1'b0);
    rdchk(CMD_REL_PCT, 16'h0019, 1'b0);
    rdchk(CMD_ABS_PCT, 16'h00c8, 1'b0);
    // Rate test in power units: 10 units left cover 3600 over ten seconds
    rate(16'h0064, 1'b1);
    rate(16'h0000, 1'b1);
    rate(16'hf1f0, 1'b1);
    rate(16'hf1ef, 1'b0);
    rdchk(CMD_RATE_OK, 16'h0000, 1'b0);
    rate(16'hf1f0, 1'b1);
    rate(16'hf1ef, 1'b0);
    // More charge left: the periodic refresh alone must raise the flag
    @(posedge ref_clk);
    left_cwh <= 16'h000b;
    n = 0;
    #1;
    while (rate_sufficiency_flag !== 1'b1 && n < REFRESH + 3) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({15'h0, rate_sufficiency_flag}, 16'h0001);
    rdchk(CMD_RATE_OK, 16'h0001, 1'b0);
    summarize();
  end
endmodule : testbench
